//--- hdl/scbd_defines.svh
// Purpose: Constants for the serial controller bus and daisy-chain interrupt block.
// Assumes: One clock, shared in frequency and phase with the processor.
// Notes: Rules of the block follow, one line per rule.
// Function
// - Channel select high picks second channel; control select high picks control.
// - Second channel has three readable status registers, first has two.
// - Non-primary status reads need a pointer byte written first.
// - Second channel has eight configuration registers, first has seven.
// - Configuration write is pointer byte, low three bits, then data byte.
// - Basic commands take one byte to the command register.
// - Hardware reset and channel reset return pointer to command register.
// - Internal daisy chain prioritises channel sources and joins external chain.
// - Chain output low while pending or in service, else follows input.
// - Interrupt status frozen while opcode fetch strobe is low.
// - On acknowledge, enabled requester drives vector and sets in-service latch.
// - First return opcode byte forces chain output high for unacknowledged pending.
// - Second return byte following clears in-service latch of serviced device.
// - Special receive error flags gathered into one status register.
// - First channel above second; receive above transmit above external status.
// - Optionally three vector bits name the interrupting source.
`ifndef SCBD_DEFINES_SVH
`define SCBD_DEFINES_SVH
`define SCBD_PTR_CMD    3'h0
`define SCBD_PTR_IEN    3'h1
`define SCBD_PTR_VEC    3'h2
`define SCBD_CMD_LSB    3
`define SCBD_CMD_MSB    5
`define SCBD_PTR_MSB    2
`define SCBD_CMD_CHRST  3'h3
`define SCBD_IEN_EXT    0
`define SCBD_IEN_TX     1
`define SCBD_IEN_RX     3
`define SCBD_IEN_SAV    2
`define SCBD_OP_PREFIX  8'hED
`define SCBD_OP_RETURN  8'h4D
`define SCBD_VEC_LSB    1
`define SCBD_VEC_MSB    3
`define SCBD_NSRC       6
`endif

//--- hdl/scbd_pkg.sv
// Purpose: Types shared by the daisy-chain interrupt block.
// Assumes: Constants come from the defines header.
// Notes: Sources are ordered highest priority first.
package scbd_pkg;
  typedef struct packed {
    logic       sel_b;
    logic       sel_ctrl;
    logic [7:0] wdata;
  } scbd_bus_t;
  typedef struct packed {
    logic rx;
    logic tx;
    logic ext;
  } scbd_chan_req_t;
  typedef enum logic [2:0] {
    SCBD_RI_IDLE = 3'b001,
    SCBD_RI_SEEN = 3'b010,
    SCBD_RI_DONE = 3'b100
  } scbd_return_from_isr_opcode_t;
endpackage : scbd_pkg

//--- hdl/scbd_ctrl.sv
// Purpose: Processor register access and daisy-chain interrupt logic.
// Assumes: Bus strobes and channel events are synchronous to clk.
// Notes: Serial data paths sit outside; they supply events and error flags.
`include "scbd_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module scbd_ctrl (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // Processor bus
  input  wire logic                   chip_en_n,
  input  wire logic                   rd_n,
  input  wire scbd_pkg::scbd_bus_t    bus,
  input  wire logic                   opcode_fetch_n,
  input  wire logic                   io_request_n,
  output logic [7:0]                  rdata_q,
  output logic                        data_oe_n_q,
  // Daisy chain
  input  wire logic                   daisy_enable_in,
  output logic                        daisy_enable_out_q,
  output logic                        int_o_q,
  output logic                        int_oe_n_q,
  // Channel side
  input  wire scbd_pkg::scbd_chan_req_t ev_a,
  input  wire scbd_pkg::scbd_chan_req_t ev_b,
  input  wire logic [7:0]             stat_a,
  input  wire logic [7:0]             stat_b,
  input  wire logic [7:0]             spec_a,
  input  wire logic [7:0]             spec_b,
  output logic                        cfg_we_q,
  output logic                        cfg_chan_q,
  output logic [2:0]                  cfg_idx_q,
  output logic [7:0]                  cfg_data_q
);
  localparam int N = `SCBD_NSRC;
  logic [2:0]   ptr_a_q, ptr_b_q;
  logic [7:0]   ien_a_q, ien_b_q, vec_q;
  logic [N-1:0] pend_q, ius_q, blk_q, req;
  logic         iei_s1_q, iei_q;
  scbd_pkg::scbd_return_from_isr_opcode_t ri_q;
  logic         m1_q, io_request_n_q, ack_now, wr, rd;
  logic [2:0]   src_code;
  logic [N-1:0] win;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [N-1:0] first_one(input logic [N-1:0] v);
    first_one = v & ~(v - N'(1));
  endfunction : first_one

  function automatic logic [2:0] enc(input logic [N-1:0] v);
    enc = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        enc = 3'(i);
      end
    end
  endfunction : enc

  // The vector leaves through both the acknowledge and the register read, so one place builds it.
  function automatic logic [7:0] vec_out(input logic [7:0] base, input logic [2:0] code, input logic sav);
    vec_out = base;
    if (sav) begin
      vec_out[`SCBD_VEC_MSB:`SCBD_VEC_LSB] = code;
    end
  endfunction : vec_out

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign wr = !chip_en_n && rd_n && io_request_n == 1'b0 && opcode_fetch_n && !io_request_n_q;
  assign rd = !chip_en_n && !rd_n && io_request_n == 1'b0 && opcode_fetch_n && !io_request_n_q;
  // Sources: bit0 A rx, A tx, A ext, B rx, B tx, B ext.
  assign req = {ev_b.ext & ien_b_q[`SCBD_IEN_EXT], ev_b.tx & ien_b_q[`SCBD_IEN_TX],
                ev_b.rx & ien_b_q[`SCBD_IEN_RX], ev_a.ext & ien_a_q[`SCBD_IEN_EXT],
                ev_a.tx & ien_a_q[`SCBD_IEN_TX], ev_a.rx & ien_a_q[`SCBD_IEN_RX]};
  assign win = first_one(pend_q & ~blk_q);
  assign src_code = enc(win);
  assign ack_now = !opcode_fetch_n && !io_request_n && !io_request_n_q && iei_q && |win;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      iei_s1_q <= 1'b0;
      iei_q    <= 1'b0;
      m1_q     <= 1'b1;
      io_request_n_q   <= 1'b0;
    end else begin
      iei_s1_q <= daisy_enable_in;
      iei_q    <= iei_s1_q;
      m1_q     <= opcode_fetch_n;
      io_request_n_q   <= !io_request_n;
    end
  end

  // ----------------------------------------
  // Pointer and configuration writes
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ptr_a_q <= `SCBD_PTR_CMD;
      ptr_b_q <= `SCBD_PTR_CMD;
      ien_a_q <= 8'h00;
      ien_b_q <= 8'h00;
      vec_q   <= 8'h00;
      cfg_we_q <= 1'b0;
      cfg_chan_q <= 1'b0;
      cfg_idx_q <= 3'h0;
      cfg_data_q <= 8'h00;
    end else begin
      cfg_we_q <= 1'b0;
      if (wr && bus.sel_ctrl) begin
        if ((bus.sel_b ? ptr_b_q : ptr_a_q) == `SCBD_PTR_CMD) begin
          // A channel reset wins over any pointer bits in the same byte.
          if (bus.wdata[`SCBD_CMD_MSB:`SCBD_CMD_LSB] == `SCBD_CMD_CHRST) begin
            if (bus.sel_b) ptr_b_q <= `SCBD_PTR_CMD;
            else ptr_a_q <= `SCBD_PTR_CMD;
          end else if (bus.sel_b) begin
            ptr_b_q <= bus.wdata[`SCBD_PTR_MSB:0];
          end else begin
            ptr_a_q <= bus.wdata[`SCBD_PTR_MSB:0];
          end
          cfg_we_q   <= 1'b1;
          cfg_chan_q <= bus.sel_b;
          cfg_idx_q  <= `SCBD_PTR_CMD;
          cfg_data_q <= bus.wdata;
        end else begin
          if (bus.sel_b) ptr_b_q <= `SCBD_PTR_CMD;
          else ptr_a_q <= `SCBD_PTR_CMD;
          if (bus.sel_b && ptr_b_q == `SCBD_PTR_VEC) vec_q <= bus.wdata;
          if (!bus.sel_b && ptr_a_q != `SCBD_PTR_VEC) begin
            cfg_we_q <= 1'b1;
          end
          if (bus.sel_b) cfg_we_q <= 1'b1;
          if (bus.sel_b && ptr_b_q == `SCBD_PTR_IEN) ien_b_q <= bus.wdata;
          if (!bus.sel_b && ptr_a_q == `SCBD_PTR_IEN) ien_a_q <= bus.wdata;
          cfg_chan_q <= bus.sel_b;
          cfg_idx_q  <= bus.sel_b ? ptr_b_q : ptr_a_q;
          cfg_data_q <= bus.wdata;
        end
      end else if (rd && bus.sel_ctrl) begin
        if (bus.sel_b) ptr_b_q <= `SCBD_PTR_CMD;
        else ptr_a_q <= `SCBD_PTR_CMD;
      end
    end
  end

  // ----------------------------------------
  // Read data and vector
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q     <= 8'h00;
      data_oe_n_q <= 1'b1;
    end else begin
      data_oe_n_q <= 1'b1;
      if (ack_now) begin
        rdata_q <= vec_out(vec_q, src_code, ien_b_q[`SCBD_IEN_SAV]);
        data_oe_n_q <= 1'b0;
      end else if (rd && bus.sel_ctrl) begin
        data_oe_n_q <= 1'b0;
        case (bus.sel_b ? ptr_b_q : ptr_a_q)
          `SCBD_PTR_IEN: rdata_q <= bus.sel_b ? spec_b : spec_a;
          `SCBD_PTR_VEC: rdata_q <= bus.sel_b ? vec_out(vec_q, src_code, ien_b_q[`SCBD_IEN_SAV])
                                              : stat_a;
          default: rdata_q <= bus.sel_b ? stat_b : stat_a;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Pending, in-service and return detect
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_q <= '0;
      ius_q  <= '0;
      blk_q  <= '0;
      ri_q   <= scbd_pkg::SCBD_RI_IDLE;
    end else begin
      if (opcode_fetch_n) pend_q <= (pend_q | req) & ~ius_q;
      if (ack_now) begin
        ius_q  <= ius_q | win;
        pend_q <= pend_q & ~win;
      end
      if (!opcode_fetch_n && m1_q && !rd_n) begin
        case (ri_q)
          scbd_pkg::SCBD_RI_IDLE: if (bus.wdata == `SCBD_OP_PREFIX) begin
            ri_q <= scbd_pkg::SCBD_RI_SEEN;
            blk_q <= pend_q;
          end
          scbd_pkg::SCBD_RI_SEEN: begin
            ri_q  <= scbd_pkg::SCBD_RI_IDLE;
            blk_q <= '0;
            // An acknowledge landing on the same edge keeps its new in-service bit.
            if (bus.wdata == `SCBD_OP_RETURN && iei_q) begin
              ius_q <= (ius_q & ~first_one(ius_q)) | (win & {N{ack_now}});
            end
          end
          default: ri_q <= scbd_pkg::SCBD_RI_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Daisy chain outputs
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      daisy_enable_out_q <= 1'b0;
      int_o_q            <= 1'b0;
      int_oe_n_q         <= 1'b1;
    end else begin
      daisy_enable_out_q <= iei_q && !(|ius_q) && !(|(pend_q & ~blk_q));
      int_oe_n_q <= !(iei_q && |(pend_q & ~blk_q) && !(|ius_q));
    end
  end

  chain_a: assert property (@(posedge clk) disable iff (reset)
    !iei_q |=> !daisy_enable_out_q) else $error("chain output high with input low");
  freeze_a: assert property (@(posedge clk) disable iff (reset)
    (!opcode_fetch_n && !ack_now) |=> pend_q == $past(pend_q)) else $error("pending changed during fetch");
  irq_gate_a: assert property (@(posedge clk) disable iff (reset)
    !int_oe_n_q |-> $past(iei_q)) else $error("request without chain input");
  ack_vec_a: assert property (@(posedge clk) disable iff (reset)
    ack_now |=> !data_oe_n_q && |ius_q) else $error("acknowledge gave no vector");
  ptr_ret_a: assert property (@(posedge clk) disable iff (reset)
    (wr && bus.sel_ctrl && !bus.sel_b && ptr_a_q != `SCBD_PTR_CMD) |=> ptr_a_q == `SCBD_PTR_CMD)
    else $error("pointer not returned");
  svc_block_a: assert property (@(posedge clk) disable iff (reset)
    (|ius_q) |=> !daisy_enable_out_q) else $error("chain output high during service");
endmodule : scbd_ctrl
`default_nettype wire

//--- testbench/scbd_nbr_model.sv
// Purpose: Higher-priority neighbour on the interrupt daisy chain.
// Assumes: Same clock as the block under test.
// Notes: DLY sets how slowly the neighbour's enable ripples down the chain.
`timescale 1ns/1ns
`default_nettype none
module scbd_nbr_model #(
  parameter int DLY = 2
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Chain
  input  wire logic busy,
  output logic      ie_out
);
  logic [3:0] dly_q;
  // Top of the chain, so its own enable input is held high for good.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dly_q <= 4'hF;
    end else begin
      dly_q <= {dly_q[2:0], ~busy};
    end
  end
  assign ie_out = dly_q[DLY-1];
endmodule : scbd_nbr_model
`default_nettype wire

//--- testbench/scbd_ctrl_test.sv
// Purpose: Self-checking bench for the bus and daisy-chain interrupt block.
// Assumes: One clock shared with the processor model.
// Notes: Reads and acknowledges note the expected byte; a monitor checks it.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module scbd_ctrl_test;
  logic clk, reset, chip_en_n, rd_n, opcode_fetch_n, io_request_n, nb_busy, daisy_in;
  logic data_oe_n_q, daisy_enable_out_q, int_oe_n_q, cfg_we_q, cfg_chan_q, int_o_q;
  logic [2:0] cfg_idx_q;
  logic [7:0] rdata_q, cfg_data_q, stat_a, stat_b, spec_a, spec_b, v, e;
  logic [11:0] last_cfg;
  logic [7:0] exp_q[$];
  scbd_pkg::scbd_bus_t bus;
  scbd_pkg::scbd_chan_req_t ev_a, ev_b;
  int n_fail = 0, checked = 0, cyc = 0, seed = 53;
  scbd_ctrl u_scbd_ctrl (.clk(clk), .reset(reset), .chip_en_n(chip_en_n), .rd_n(rd_n), .bus(bus),
    .opcode_fetch_n(opcode_fetch_n), .io_request_n(io_request_n), .rdata_q(rdata_q), .data_oe_n_q(data_oe_n_q),
    .daisy_enable_in(daisy_in), .daisy_enable_out_q(daisy_enable_out_q), .int_o_q(int_o_q), .int_oe_n_q(int_oe_n_q),
    .ev_a(ev_a), .ev_b(ev_b), .stat_a(stat_a), .stat_b(stat_b), .spec_a(spec_a), .spec_b(spec_b),
    .cfg_we_q(cfg_we_q), .cfg_chan_q(cfg_chan_q), .cfg_idx_q(cfg_idx_q), .cfg_data_q(cfg_data_q));
  scbd_nbr_model #(.DLY(2)) u_scbd_nbr_model (.clk(clk), .reset(reset), .busy(nb_busy), .ie_out(daisy_in));
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w
  task automatic io(input logic b, input logic c, input logic rd, input logic [7:0] d);
    chip_en_n = 1'b0;
    rd_n = rd;
    bus = '{b, c, d};
    io_request_n = 1'b0;
    w(2);
    chip_en_n = 1'b1;
    rd_n = 1'b1;
    io_request_n = 1'b1;
    w(1);
  endtask : io
  task automatic rdx(input logic b, input logic c, input logic [7:0] x);
    exp_q.push_back(x);
    io(b, c, 1'b0, 8'h00);
  endtask : rdx
  task automatic fetch(input logic [7:0] op);
    opcode_fetch_n = 1'b0;
    rd_n = 1'b0;
    bus.wdata = op;
    w(2);
    opcode_fetch_n = 1'b1;
    rd_n = 1'b1;
    w(1);
  endtask : fetch
  task automatic ack(input logic [7:0] x);
    exp_q.push_back(x);
    opcode_fetch_n = 1'b0;
    w(2);
    io_request_n = 1'b0;
    w(2);
    opcode_fetch_n = 1'b1;
    io_request_n = 1'b1;
    w(1);
  endtask : ack
  task automatic test_done;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // Monitors
  // ----------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cfg_we_q === 1'b1) last_cfg = {cfg_chan_q, cfg_idx_q, cfg_data_q};
    if (!reset && data_oe_n_q === 1'b0) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("[ERR] %0t unexpected bus drive", $time);
      end else begin
        e = exp_q.pop_front();
        `CHK(rdata_q, e)
      end
    end
    if (cyc == 5000) begin
      n_fail++;
      test_done;
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {chip_en_n, rd_n, opcode_fetch_n, io_request_n, reset, nb_busy} = 6'h3E;
    bus = '0;
    ev_a = '0;
    ev_b = '0;
    {stat_a, stat_b, spec_a, spec_b} = 32'($random(seed));
    v = 8'($random(seed));
    w(20);
    reset = 1'b0;
    w(4);
    `CHK(int_oe_n_q, 1'b1)
    `CHK(daisy_enable_out_q, 1'b1)
    io(1'b1, 1'b1, 1'b1, 8'h02);
    io(1'b1, 1'b1, 1'b1, v);
    io(1'b1, 1'b1, 1'b1, 8'h02);
    rdx(1'b1, 1'b1, v);
    rdx(1'b1, 1'b1, stat_b);
    io(1'b0, 1'b1, 1'b1, 8'h01);
    rdx(1'b0, 1'b1, spec_a);
    io(1'b0, 1'b1, 1'b1, 8'h05);
    io(1'b0, 1'b1, 1'b1, ~v);
    `CHK(last_cfg, {1'b0, 3'h5, ~v})
    io(1'b1, 1'b1, 1'b1, 8'h01);
    reset = 1'b1;
    w(1);
    reset = 1'b0;
    w(3);
    rdx(1'b1, 1'b1, stat_b);
    io(1'b1, 1'b1, 1'b1, 8'h18);
    rdx(1'b1, 1'b1, stat_b);
    io(1'b1, 1'b1, 1'b1, 8'h02);
    io(1'b1, 1'b1, 1'b1, v);
    io(1'b0, 1'b1, 1'b1, 8'h02);
    io(1'b0, 1'b1, 1'b1, ~v);
    `CHK(last_cfg, {1'b0, 3'h0, 8'h02})
    io(1'b1, 1'b1, 1'b1, 8'h01);
    io(1'b1, 1'b1, 1'b1, 8'h08);
    ev_b = '{1'b1, 1'b0, 1'b0};
    w(1);
    ev_b = '0;
    w(3);
    `CHK(int_oe_n_q, 1'b0)
    `CHK(int_o_q, 1'b0)
    `CHK(daisy_enable_out_q, 1'b0)
    nb_busy = 1'b1;
    w(6);
    `CHK(int_oe_n_q, 1'b1)
    nb_busy = 1'b0;
    w(6);
    fetch(8'hED);
    `CHK(daisy_enable_out_q, 1'b1)
    fetch(8'h00);
    ack(v);
    w(2);
    `CHK(int_oe_n_q, 1'b1)
    `CHK(daisy_enable_out_q, 1'b0)
    fetch(8'hED);
    fetch(8'h4D);
    w(3);
    `CHK(daisy_enable_out_q, 1'b1)
    io(1'b1, 1'b1, 1'b1, 8'h01);
    io(1'b1, 1'b1, 1'b1, 8'h0C);
    ev_b = '{1'b1, 1'b0, 1'b0};
    w(1);
    ev_b = '0;
    w(3);
    ack({v[7:4], 3'h3, v[0]});
    fetch(8'hED);
    fetch(8'h4D);
    w(3);
    `CHK(daisy_enable_out_q, 1'b1)
    `CHK(exp_q.size(), 0)
    test_done;
  end
endmodule : scbd_ctrl_test
`default_nettype wire
